// ==== core/smx_regs.vh ====
// Purpose: Register map, field positions and timing constants of the SMBus extension.
// Assumes: 32-bit classic Wishbone with word-aligned registers.
// Notes: All counts are in kernel clock cycles.
`ifndef SMX_REGS_VH
`define SMX_REGS_VH

// Register byte offsets
`define SMX_CTRL_ADDR 8'h00
`define SMX_XFER_ADDR 8'h04
`define SMX_TIMER_ADDR 8'h08
`define SMX_STATUS_ADDR 8'h0C
`define SMX_CRC_ADDR 8'h10
`define SMX_OWNADDR_ADDR 8'h14

// Control fields
`define SMX_CTRL_ENABLE 0
`define SMX_CTRL_DEFAULT_ADDR_EN 1
`define SMX_CTRL_HOST_MODE_EN 2
`define SMX_CTRL_NOTICE_EN 3
`define SMX_CTRL_ERR_IRQ_EN 4
`define SMX_CTRL_SLAVE_ACK_CTRL 5
`define SMX_CTRL_CRC_EN 6

// Transfer fields
`define SMX_XFER_COUNT_LSB 0
`define SMX_XFER_COUNT_MSB 7
`define SMX_XFER_REFILL 8
`define SMX_XFER_AUTO_FINISH 9
`define SMX_XFER_CRC_REQ 10

// Timer fields
`define SMX_TMR_A_LSB 0
`define SMX_TMR_A_MSB 11
`define SMX_TMR_IDLE_SEL 12
`define SMX_TMR_LOW_EN 15
`define SMX_TMR_B_LSB 16
`define SMX_TMR_B_MSB 27
`define SMX_TMR_STRETCH_EN 31

// Status fields (write one to clear flags)
`define SMX_ST_NOTICE 0
`define SMX_ST_STALL 1
`define SMX_ST_CRC_ERR 2
`define SMX_ST_IRQ 3
`define SMX_ST_NOTICE_IN 4

// Special addresses (seven bit)
`define SMX_DEFAULT_ADDR 7'h61
`define SMX_HOST_ADDR 7'h08
`define SMX_ALERT_RESP_ADDR 7'h0C

// Timer scaling and CRC generator
`define SMX_LOW_UNIT 24'h000800
`define SMX_IDLE_UNIT 16'h0004
`define SMX_CRC_POLY 8'h07

`endif

// ==== core/smx_crc8.v ====
// Purpose: CRC-8 accumulator with generator x^8+x^2+x+1.
// Assumes: One byte folded in per pulse of byte_valid_i.
// Notes: Clear wins over a byte in the same cycle.
`include "smx_regs.vh"
`default_nettype none
module smx_crc8 (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Control
	input wire clear_i,
	input wire byte_valid_i,
	input wire [7:0] byte_i,
	// Result
	output reg [7:0] crc_o
);
	reg [7:0] crc_nxt;
	integer k;

	// Bitwise MSB-first update
	always @* begin
		crc_nxt = crc_o ^ byte_i;
		for (k = 0; k < 8; k = k + 1) begin
			if (crc_nxt[7]) begin
				crc_nxt = {crc_nxt[6:0], 1'b0} ^ `SMX_CRC_POLY;
			end else begin
				crc_nxt = {crc_nxt[6:0], 1'b0};
			end
		end
	end

	// Accumulator register
	always @(posedge clk_i) begin
		if (rst_i || clear_i) begin
			crc_o <= 8'h00;
		end else if (byte_valid_i) begin
			crc_o <= crc_nxt;
		end
	end
endmodule // smx_crc8
`default_nettype wire

// ==== core/smx_sync2.v ====
// Purpose: Two-flop synchroniser for a bundle of pin inputs.
// Assumes: Inputs are asynchronous levels.
// Notes: Resets to high, the idle level of the bus pins.
`default_nettype none
module smx_sync2 #(
	parameter W = 3
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Data
	input wire [W-1:0] d_i,
	output reg [W-1:0] q_o
);
	reg [W-1:0] meta_r;

	// Two stages, the first read only by the second
	always @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= {W{1'b1}};
			q_o <= {W{1'b1}};
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule // smx_sync2
`default_nettype wire

// ==== core/smx_ext.v ====
// Purpose: SMBus extension logic beside a two-wire controller kernel.
// Assumes: Kernel reports START, address and byte events on its clock.
// Notes: Pins pass a two-flop synchroniser before use.
//
// Overview of operation
// - With default_addr_enable set, acknowledge device default address too.
// - With host_mode_enable set, acknowledge the host address.
// - Slave with notice_line_enable drives notice_pin low, enables alert response.
// - Host with notice enabled: falling notice_pin sets flag, irq if enabled.
// - Notice disabled: internal alert line reads high whatever the pin.
// - Alert response acknowledged only while this device holds alert low.
// - Arbitration continues while acting as slave.
// - CRC-8 x^8+x^2+x+1 over the bytes from byte_valid_i; address events are not folded in.
// - Received code byte differing from computed one is NACKed.
// - CRC computed only when enabled; change it only while disabled.
// - Code byte after byte_count minus one bytes; refill mode disables request.
// - Idle select 0: SCL low beyond (limit+1)*2048 cycles sets stall flag.
// - Idle select 1: both lines high beyond (limit+1)*4 cycles sets stall.
// - Own stretching beyond (stretch_limit+1)*2048 cycles sets stall flag.
// - auto_finish at count end without refill requests STOP, else completion.
// - tx_request pulses equal byte_count, one fewer with a code byte; longer transfers need refill mode.
`include "smx_regs.vh"
`default_nettype none
module smx_ext (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Bus pins
	input wire scl_i,
	input wire sda_i,
	input wire notice_pin_i,
	output wire notice_pin_o,
	output wire notice_pin_oe_o,
	// Kernel events
	input wire start_i,
	input wire stop_i,
	input wire addr_valid_i,
	input wire [6:0] addr_i,
	input wire byte_valid_i,
	input wire [7:0] byte_i,
	input wire rx_dir_i,
	input wire stretch_i,
	input wire arb_lost_i,
	// Kernel controls
	output reg addr_ack_o,
	output wire arb_enable_o,
	output reg crc_nack_o,
	output reg crc_send_o,
	output wire [7:0] crc_o,
	output reg tx_request_o,
	output reg stop_req_o,
	output reg done_o,
	output wire irq_o
);
	// Registers
	reg [6:0] ctrl_r;
	reg [10:0] xfer_r;
	reg [31:0] timer_r;
	reg [6:0] own_addr_r;
	reg notice_flag_r;
	reg stall_flag_r;
	reg crc_err_r;
	reg notice_prev_r;
	reg [8:0] byte_cnt_r;
	reg [23:0] low_cnt_r;
	reg [23:0] str_cnt_r;
	reg [15:0] idle_cnt_r;
	reg [31:0] rd_nxt;
	wire [2:0] pins_s;
	wire scl_s;
	wire sda_s;
	wire notice_s;
	wire wb_req;
	wire wr_ctrl;
	wire wr_xfer;
	wire wr_timer;
	wire wr_status;
	wire wr_own;
	wire enabled;
	wire host_mode;
	wire notice_en;
	wire alert_line;
	wire crc_en;
	wire crc_req;
	wire refill;
	wire [7:0] count;
	wire crc_slot;
	wire [23:0] low_lim;
	wire [15:0] idle_lim;
	wire [23:0] str_lim;
	wire low_trip;
	wire idle_trip;
	wire str_trip;
	wire notice_fall;
	wire crc_mismatch;
	wire [7:0] crc_val;

	// Field views
	assign enabled = ctrl_r[`SMX_CTRL_ENABLE];
	assign host_mode = ctrl_r[`SMX_CTRL_HOST_MODE_EN];
	assign notice_en = ctrl_r[`SMX_CTRL_NOTICE_EN];
	assign crc_en = ctrl_r[`SMX_CTRL_CRC_EN];
	assign count = xfer_r[`SMX_XFER_COUNT_MSB:`SMX_XFER_COUNT_LSB];
	assign refill = xfer_r[`SMX_XFER_REFILL];
	assign crc_req = xfer_r[`SMX_XFER_CRC_REQ] & ~refill;
	assign crc_val = crc_o;

	// Pin synchroniser
	smx_sync2 #(.W(3)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({scl_i, sda_i, notice_pin_i}),
		.q_o(pins_s)
	);
	assign scl_s = pins_s[2];
	assign sda_s = pins_s[1];
	assign notice_s = pins_s[0];

	// Notice pin: open drain, driven low in slave mode with notice enabled
	assign notice_pin_o = 1'b0;
	assign notice_pin_oe_o = notice_en & ~host_mode;
	assign alert_line = notice_en ? notice_s : 1'b1;
	assign notice_fall = notice_prev_r & ~alert_line;

	// Arbitration stays on in slave role
	assign arb_enable_o = enabled;

	// Wishbone decode
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_ctrl = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `SMX_CTRL_ADDR);
	assign wr_xfer = wb_req & wb_we_i & (wb_adr_i == `SMX_XFER_ADDR);
	assign wr_timer = wb_req & wb_we_i & (wb_adr_i == `SMX_TIMER_ADDR);
	assign wr_status = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `SMX_STATUS_ADDR);
	assign wr_own = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `SMX_OWNADDR_ADDR);

	// Register writes; byte lanes honoured per byte
	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= 7'h00;
			xfer_r <= 11'h000;
			timer_r <= 32'h00000000;
			own_addr_r <= 7'h00;
		end else begin
			if (wr_ctrl) begin
				// CRC enable only changes while disabled or in the write that clears enable
				if (enabled && wb_dat_i[`SMX_CTRL_ENABLE]) begin
					ctrl_r <= {crc_en, wb_dat_i[5:0]};
				end else begin
					ctrl_r <= wb_dat_i[6:0];
				end
			end
			if (wr_xfer) begin
				if (wb_sel_i[0]) xfer_r[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1]) xfer_r[10:8] <= wb_dat_i[10:8];
			end
			if (wr_timer) begin
				if (wb_sel_i[0]) timer_r[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1]) timer_r[15:8] <= wb_dat_i[15:8];
				if (wb_sel_i[2]) timer_r[23:16] <= wb_dat_i[23:16];
				if (wb_sel_i[3]) timer_r[31:24] <= wb_dat_i[31:24];
			end
			if (wr_own) begin
				own_addr_r <= wb_dat_i[6:0];
			end
		end
	end

	// Read mux
	always @* begin
		rd_nxt = 32'h00000000;
		case (wb_adr_i)
			`SMX_CTRL_ADDR: rd_nxt = {25'h0000000, ctrl_r};
			`SMX_XFER_ADDR: rd_nxt = {21'h000000, xfer_r};
			`SMX_TIMER_ADDR: rd_nxt = timer_r;
			`SMX_STATUS_ADDR: rd_nxt = {27'h0000000, notice_s, irq_o,
				crc_err_r, stall_flag_r, notice_flag_r};
			`SMX_CRC_ADDR: rd_nxt = {24'h000000, crc_val};
			`SMX_OWNADDR_ADDR: rd_nxt = {25'h0000000, own_addr_r};
			default: rd_nxt = 32'h00000000;
		endcase
	end

	// Ack one cycle after request; unmapped reads zero
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				wb_dat_o <= rd_nxt;
			end
		end
	end

	// Address match for own and special addresses
	always @(posedge clk_i) begin
		if (rst_i) begin
			addr_ack_o <= 1'b0;
		end else begin
			addr_ack_o <= 1'b0;
			if (addr_valid_i && enabled) begin
				if (addr_i == own_addr_r) begin
					addr_ack_o <= 1'b1;
				end
				if (ctrl_r[`SMX_CTRL_DEFAULT_ADDR_EN] && addr_i == `SMX_DEFAULT_ADDR) begin
					addr_ack_o <= 1'b1;
				end
				if (host_mode && addr_i == `SMX_HOST_ADDR) begin
					addr_ack_o <= 1'b1;
				end
				if (notice_pin_oe_o && addr_i == `SMX_ALERT_RESP_ADDR) begin
					addr_ack_o <= 1'b1;
				end
			end
		end
	end

	// CRC engine, cleared at each START
	smx_crc8 u_crc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(start_i | ~crc_en),
		.byte_valid_i(crc_en & (byte_valid_i & ~crc_slot)),
		.byte_i(byte_i),
		.crc_o(crc_o)
	);

	// Code byte slot: after count minus one data bytes
	assign crc_slot = crc_en & crc_req & (byte_cnt_r == {1'b0, count} - 9'd1);
	assign crc_mismatch = crc_slot & byte_valid_i & rx_dir_i & (byte_i != crc_val);

	// Byte counter, request pulses, finish handling
	always @(posedge clk_i) begin
		if (rst_i) begin
			byte_cnt_r <= 9'h000;
			tx_request_o <= 1'b0;
			crc_send_o <= 1'b0;
			crc_nack_o <= 1'b0;
			stop_req_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			tx_request_o <= 1'b0;
			crc_nack_o <= 1'b0;
			stop_req_o <= 1'b0;
			crc_send_o <= crc_slot & ~rx_dir_i;
			if (start_i || wr_xfer) begin
				byte_cnt_r <= 9'h000;
				done_o <= 1'b0;
			end else if (byte_valid_i && byte_cnt_r < {1'b0, count}) begin
				byte_cnt_r <= byte_cnt_r + 9'd1;
				if (crc_mismatch) begin
					crc_nack_o <= 1'b1;
				end
				// One request per transmitted data byte, none for the code byte
				if (!rx_dir_i && !crc_slot) begin
					tx_request_o <= 1'b1;
				end
				if (byte_cnt_r + 9'd1 == {1'b0, count} && !refill) begin
					if (xfer_r[`SMX_XFER_AUTO_FINISH]) begin
						stop_req_o <= 1'b1;
					end else begin
						done_o <= 1'b1;
					end
				end
			end
		end
	end

	// Timer limits
	assign low_lim = ({12'h000, timer_r[`SMX_TMR_A_MSB:`SMX_TMR_A_LSB]} + 24'd1) * `SMX_LOW_UNIT;
	assign idle_lim = ({4'h0, timer_r[`SMX_TMR_A_MSB:`SMX_TMR_A_LSB]} + 16'd1) * `SMX_IDLE_UNIT;
	assign str_lim = ({12'h000, timer_r[`SMX_TMR_B_MSB:`SMX_TMR_B_LSB]} + 24'd1) * `SMX_LOW_UNIT;
	assign low_trip = low_cnt_r > low_lim;
	assign idle_trip = idle_cnt_r > idle_lim;
	assign str_trip = str_cnt_r > str_lim;

	// Clock-low, idle and stretch counters
	always @(posedge clk_i) begin
		if (rst_i) begin
			low_cnt_r <= 24'h000000;
			idle_cnt_r <= 16'h0000;
			str_cnt_r <= 24'h000000;
		end else begin
			if (!timer_r[`SMX_TMR_LOW_EN] || timer_r[`SMX_TMR_IDLE_SEL] || scl_s) begin
				low_cnt_r <= 24'h000000;
			end else if (!low_trip) begin
				low_cnt_r <= low_cnt_r + 24'd1;
			end
			if (!timer_r[`SMX_TMR_LOW_EN] || !timer_r[`SMX_TMR_IDLE_SEL] || !(scl_s && sda_s)) begin
				idle_cnt_r <= 16'h0000;
			end else if (!idle_trip) begin
				idle_cnt_r <= idle_cnt_r + 16'd1;
			end
			if (!timer_r[`SMX_TMR_STRETCH_EN] || start_i) begin
				str_cnt_r <= 24'h000000;
			end else if (stretch_i && !str_trip) begin
				str_cnt_r <= str_cnt_r + 24'd1;
			end
		end
	end

	// Sticky flags; set wins over clear
	always @(posedge clk_i) begin
		if (rst_i) begin
			notice_prev_r <= 1'b1;
			notice_flag_r <= 1'b0;
			stall_flag_r <= 1'b0;
			crc_err_r <= 1'b0;
		end else begin
			notice_prev_r <= alert_line;
			if (host_mode && notice_en && notice_fall) begin
				notice_flag_r <= 1'b1;
			end else if (wr_status && wb_dat_i[`SMX_ST_NOTICE]) begin
				notice_flag_r <= 1'b0;
			end
			if ((low_trip && !low_cnt_r[0]) || low_trip || idle_trip || str_trip) begin
				stall_flag_r <= 1'b1;
			end else if (wr_status && wb_dat_i[`SMX_ST_STALL]) begin
				stall_flag_r <= 1'b0;
			end
			if (crc_mismatch) begin
				crc_err_r <= 1'b1;
			end else if (wr_status && wb_dat_i[`SMX_ST_CRC_ERR]) begin
				crc_err_r <= 1'b0;
			end
		end
	end

	// Error interrupt gated by error_irq_enable
	assign irq_o = ctrl_r[`SMX_CTRL_ERR_IRQ_EN] &
		(notice_flag_r | stall_flag_r | crc_err_r);
endmodule // smx_ext
`default_nettype wire

// ==== verif/smx_ext_checker.sv ====
// Purpose: Port-level assertions for smx_ext.
// Assumes: Bound to every smx_ext instance, one clock domain.
// Notes: Sees only the ports of the top module.
`include "smx_regs.vh"
`default_nettype none
module smx_ext_checker (
	// Clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// Pins and kernel side
	input wire logic notice_pin_o,
	input wire logic notice_pin_oe_o,
	input wire logic arb_enable_o,
	input wire logic start_i,
	input wire logic addr_valid_i,
	input wire logic [6:0] addr_i,
	input wire logic addr_ack_o,
	input wire logic byte_valid_i,
	input wire logic rx_dir_i,
	input wire logic crc_nack_o,
	input wire logic [7:0] crc_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Steps of a bus request and of an alert poll
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_alert;
		addr_valid_i && addr_i == `SMX_ALERT_RESP_ADDR && !notice_pin_oe_o;
	endsequence
	property p_ack;
		s_req |=> wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_ack_drop;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("ack held");
	property p_addr_cause;
		addr_ack_o |-> $past(addr_valid_i);
	endproperty
	a_addr_cause: assert property (p_addr_cause) else $error("stray ack");
	property p_alert_refuse;
		s_alert |=> !addr_ack_o;
	endproperty
	a_alert_refuse: assert property (p_alert_refuse) else $error("alert acked");
	property p_oe_low;
		notice_pin_oe_o |-> !notice_pin_o;
	endproperty
	a_oe_low: assert property (p_oe_low) else $error("pin driven high");
	property p_oe_cause;
		$changed(notice_pin_oe_o) |-> $past(wb_cyc_i);
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("oe moved");
	property p_arb_cause;
		$changed(arb_enable_o) |-> $past(wb_cyc_i);
	endproperty
	a_arb_cause: assert property (p_arb_cause) else $error("arb moved");
	property p_crc_clear;
		start_i |=> crc_o == 8'h00;
	endproperty
	a_crc_clear: assert property (p_crc_clear) else $error("crc not cleared");
	property p_crc_hold;
		!start_i && !byte_valid_i && !addr_valid_i && !wb_cyc_i |=> $stable(crc_o);
	endproperty
	a_crc_hold: assert property (p_crc_hold) else $error("crc drift");
	property p_nack_cause;
		crc_nack_o |-> $past(byte_valid_i && rx_dir_i);
	endproperty
	a_nack_cause: assert property (p_nack_cause) else $error("stray nack");
endmodule // smx_ext_checker
bind smx_ext smx_ext_checker chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.notice_pin_o, .notice_pin_oe_o, .arb_enable_o, .start_i, .addr_valid_i, .addr_i,
	.addr_ack_o, .byte_valid_i, .rx_dir_i, .crc_nack_o, .crc_o);
`default_nettype wire

// ==== verif/smx_bus_model.sv ====
// Purpose: Other SMBus parties on the wires.
// Assumes: Lines pulled up when released.
// Notes: Clock runs only inside a frame.
`default_nettype none
module smx_bus_model (
	// Frame control
	input wire logic run_i,
	input wire logic hold_low_i,
	input wire logic pull_i,
	input wire logic oe_i,
	// Lines
	output wire logic scl_o,
	output wire logic sda_o,
	output wire logic notice_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic tick = 1'b1;
	// Link clock of 800 ns, still between frames
	always #400 tick = run_i ? ~tick : 1'b1;
	// Open-drain lines with pull-ups
	assign scl_o = tick & ~hold_low_i;
	assign sda_o = 1'b1;
	assign notice_o = ~(pull_i | oe_i);
endmodule // smx_bus_model
`default_nettype wire

// ==== verif/test_smx_ext.sv ====
// Purpose: Self-checking bench for smx_ext.
// Assumes: Kernel events driven by the bench.
// Notes: Small timer limits keep the run short.
`include "smx_regs.vh"
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module test_smx_ext;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [7:0] wb_adr_i = 0, byte_i = 0, crc_o;
	logic [3:0] wb_sel_i = 0;
	logic [31:0] wb_dat_i = 0, wb_dat_o, q;
	logic start_i = 0, stop_i = 0, addr_valid_i = 0, byte_valid_i = 0, rx_dir_i = 0;
	logic stretch_i = 0, arb_lost_i = 0, run = 0, hold = 0, pull = 0, ak, nk;
	logic [6:0] addr_i = 0;
	wire logic scl_i, sda_i, notice_pin_i;
	logic wb_ack_o, notice_pin_o, notice_pin_oe_o, addr_ack_o, arb_enable_o, crc_nack_o;
	logic crc_send_o, tx_request_o, stop_req_o, done_o, irq_o;
	int num_errors = 0, check_count = 0, stop_n = 0, cyc_n = 0, tx_n = 0;
	// Table of {ctrl, expected ack, address}
	logic [15:0] tab [9] = '{16'h0161, 16'h03E1, 16'h0108, 16'h0588, 16'h098C,
		16'h010C, 16'h0D0C, 16'h01AA, 16'h012B};
	smx_ext uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .scl_i, .sda_i, .notice_pin_i, .notice_pin_o,
		.notice_pin_oe_o, .start_i, .stop_i, .addr_valid_i, .addr_i, .byte_valid_i,
		.byte_i, .rx_dir_i, .stretch_i, .arb_lost_i, .addr_ack_o, .arb_enable_o,
		.crc_nack_o, .crc_send_o, .crc_o, .tx_request_o, .stop_req_o, .done_o, .irq_o);
	smx_bus_model peer (.run_i(run), .hold_low_i(hold), .pull_i(pull),
		.oe_i(notice_pin_oe_o), .scl_o(scl_i), .sda_o(sda_i), .notice_o(notice_pin_i));
	always #50 clk_i = ~clk_i;
	// Stop and tx request tally and hang guard
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (stop_req_o === 1'b1) stop_n <= stop_n + 1;
		if (tx_request_o === 1'b1) tx_n <= tx_n + 1;
		if (cyc_n == 20000) begin
			num_errors++;
			complete_run;
		end
	end
	task complete_run;
		$display("Errors %0d, checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Classic single Wishbone cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		@(posedge clk_i);
	endtask
	task automatic rs;
		wb(0, `SMX_STATUS_ADDR, 0);
	endtask
	task automatic sta;
		start_i <= 1;
		@(posedge clk_i);
		start_i <= 0;
		@(posedge clk_i);
	endtask
	task automatic adr(input logic [6:0] a);
		addr_valid_i <= 1;
		addr_i <= a;
		@(posedge clk_i);
		addr_valid_i <= 0;
		@(posedge clk_i);
		ak = addr_ack_o;
	endtask
	task automatic byt(input logic [7:0] d, input logic rx);
		byte_valid_i <= 1;
		byte_i <= d;
		rx_dir_i <= rx;
		@(posedge clk_i);
		byte_valid_i <= 0;
		@(posedge clk_i);
		nk = crc_nack_o;
	endtask
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		c = c ^ d;
		repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ `SMX_CRC_POLY : {c[6:0], 1'b0};
		return c;
	endfunction
	task automatic t_regs;
		wb(0, `SMX_CTRL_ADDR, 0);
		`CHK("ctrl", 32'h0, q)
		wb(0, 8'h20, 32'hFF);
		`CHK("unmapped", 32'h0, q)
		wb(1, `SMX_CTRL_ADDR, 32'h40);
		wb(1, `SMX_CTRL_ADDR, 32'h41);
		wb(1, `SMX_CTRL_ADDR, 32'h01);
		wb(0, `SMX_CTRL_ADDR, 0);
		`CHK("crc lock", 1'b1, q[`SMX_CTRL_CRC_EN])
		`CHK("arb", 1'b1, arb_enable_o)
	endtask
	task automatic t_addr;
		wb(1, `SMX_OWNADDR_ADDR, 32'h2A);
		foreach (tab[i]) begin
			wb(1, `SMX_CTRL_ADDR, {24'h0, tab[i][15:8]});
			adr(tab[i][6:0]);
			`CHK("addr ack", tab[i][7], ak)
			`CHK("oe", tab[i][11] & ~tab[i][10], notice_pin_oe_o)
		end
	endtask
	task automatic t_crc;
		logic [7:0] c;
		c = crc8(crc8(8'h00, 8'h5A), 8'hC3);
		wb(1, `SMX_CTRL_ADDR, 32'h00);
		wb(1, `SMX_CTRL_ADDR, 32'h40);
		wb(1, `SMX_CTRL_ADDR, 32'h61);
		wb(1, `SMX_XFER_ADDR, 32'h403);
		sta;
		byt(8'h5A, 1);
		byt(8'hC3, 1);
		`CHK("crc", c, crc_o)
		wb(0, `SMX_CRC_ADDR, 0);
		`CHK("crc reg", c, q[7:0])
		byt(~c, 1);
		`CHK("bad code", 1'b1, nk)
		rs;
		`CHK("crc err", 1'b1, q[`SMX_ST_CRC_ERR])
		wb(1, `SMX_STATUS_ADDR, 32'h4);
		sta;
		`CHK("crc clr", 8'h00, crc_o)
		byt(8'h5A, 1);
		byt(8'hC3, 1);
		byt(c, 1);
		`CHK("good code", 1'b0, nk)
		wb(1, `SMX_XFER_ADDR, 32'h403);
		sta;
		byt(8'h5A, 0);
		byt(8'hC3, 0);
		wt(1);
		`CHK("send", 1'b1, crc_send_o)
		wb(1, `SMX_XFER_ADDR, 32'h503);
		sta;
		byt(8'h5A, 0);
		byt(8'hC3, 0);
		wt(1);
		`CHK("refill", 1'b0, crc_send_o)
	endtask
	task automatic t_end;
		int b;
		b = tx_n;
		wb(1, `SMX_XFER_ADDR, 32'h202);
		sta;
		byt(8'h11, 0);
		byt(8'h22, 0);
		wt(3);
		`CHK("auto stop", 1, stop_n)
		`CHK("tx req", 2, tx_n - b)
		wb(1, `SMX_XFER_ADDR, 32'h002);
		sta;
		byt(8'h11, 0);
		byt(8'h22, 0);
		wt(3);
		`CHK("done", 1'b1, done_o)
		`CHK("no stop", 1, stop_n)
	endtask
	task automatic t_notice;
		wb(1, `SMX_CTRL_ADDR, 32'h1D);
		pull <= 1;
		wt(6);
		rs;
		`CHK("notice", 1'b1, q[`SMX_ST_NOTICE])
		`CHK("irq", 1'b1, irq_o)
		wb(1, `SMX_STATUS_ADDR, 32'h1);
		pull <= 0;
		`CHK("irq clr", 1'b0, irq_o)
		wb(1, `SMX_CTRL_ADDR, 32'h05);
		pull <= 1;
		wt(6);
		rs;
		`CHK("gated", 1'b0, q[`SMX_ST_NOTICE])
		`CHK("line", 1'b0, q[`SMX_ST_NOTICE_IN])
		pull <= 0;
	endtask
	task automatic t_timers;
		wb(1, `SMX_TIMER_ADDR, 32'h8000);
		hold <= 1;
		wt(1990);
		rs;
		`CHK("low early", 1'b0, q[`SMX_ST_STALL])
		wt(100);
		rs;
		`CHK("low late", 1'b1, q[`SMX_ST_STALL])
		hold <= 0;
		wb(1, `SMX_TIMER_ADDR, 0);
		wb(1, `SMX_STATUS_ADDR, 32'h2);
		wb(1, `SMX_TIMER_ADDR, 32'h9003);
		run <= 1;
		wt(80);
		rs;
		`CHK("idle busy", 1'b0, q[`SMX_ST_STALL])
		run <= 0;
		wt(8);
		rs;
		`CHK("idle early", 1'b0, q[`SMX_ST_STALL])
		wt(20);
		rs;
		`CHK("idle late", 1'b1, q[`SMX_ST_STALL])
		wb(1, `SMX_TIMER_ADDR, 0);
		wb(1, `SMX_STATUS_ADDR, 32'h2);
		wb(1, `SMX_TIMER_ADDR, 32'h8000_0000);
		stretch_i <= 1;
		wt(1000);
		stretch_i <= 0;
		wt(50);
		stretch_i <= 1;
		wt(990);
		stretch_i <= 0;
		rs;
		`CHK("ext early", 1'b0, q[`SMX_ST_STALL])
		stretch_i <= 1;
		wt(100);
		rs;
		`CHK("ext late", 1'b1, q[`SMX_ST_STALL])
		stretch_i <= 0;
	endtask
	// Main sequence
	initial begin
		wt(5);
		rst_i <= 0;
		t_regs;
		t_addr;
		t_crc;
		t_end;
		t_notice;
		t_timers;
		complete_run;
	end
endmodule // test_smx_ext
`default_nettype wire
